/* File: src/bst_bscan.sv */
// boundary chain: capture, shift and update stages of the pin cells
`timescale 1ns/1ps
module bst_bscan
  import bst_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  input  wire logic              capture_i,
  input  wire logic              shift_i,
  input  wire logic              update_i,
  input  wire logic              tdi_i,
  input  wire logic [BS_LEN-1:0] pin_i,
  output logic                   so_o,
  output logic      [BS_LEN-1:0] upd_o
);
  logic [BS_LEN-1:0] sh_r;

  assign so_o = sh_r[0];

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sh_r <= BS_RST;
    else if (capture_i)
      sh_r <= pin_i;
    else if (shift_i)
      sh_r <= {tdi_i, sh_r[BS_LEN-1:1]};
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      upd_o <= BS_RST;
    else if (update_i)
      upd_o <= sh_r;
  end
endmodule : bst_bscan

/* File: src/bst_pkg.sv */
// package: tap states, instruction codes, chain lengths, reset values
package bst_pkg;

  localparam int unsigned IR_W       = 4;
  localparam int unsigned BS_LEN     = 24;
  localparam int unsigned ID_LEN     = 32;
  localparam int unsigned RADDR_W    = 7;
  localparam int unsigned RDATA_W    = 8;
  localparam int unsigned RACC_LEN   = RADDR_W + RDATA_W;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned ONES_TO_RESET = 5;

  localparam logic [IR_W-1:0] IR_BYPASS = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] IR_USER   = 4'h3;
  localparam logic [IR_W-1:0] IR_CLAMP  = 4'h4;
  localparam logic [IR_W-1:0] IR_HIGHZ  = 4'h5;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h7;
  localparam logic [IR_W-1:0] IR_IFSW   = 4'h8;
  localparam logic [IR_W-1:0] IR_RREAD  = 4'h9;
  localparam logic [IR_W-1:0] IR_RWRITE = 4'hA;
  localparam logic [IR_W-1:0] IR_CAPT   = 4'h1;

  // arbitrary identification value, lsb fixed at 1
  localparam logic [ID_LEN-1:0] ID_VALUE = 32'h1000_0001;

  localparam logic [ID_LEN-1:0]  DR_RST   = 32'h0000_0000;
  localparam logic [BS_LEN-1:0]  BS_RST   = 24'h00_0000;
  localparam logic [RADDR_W-1:0] RADDR_RST = 7'h00;
  localparam logic [RDATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [2:0]         ONES_RST = 3'h0;
  localparam logic [2:0]         ONES_MAX = 3'h5;
  localparam logic [2:0]         PULL_ON  = 3'h7;

  typedef enum logic [3:0] {
    TLR   = 4'b0000,
    RTI   = 4'b0001,
    SELDR = 4'b0010,
    CAPDR = 4'b0011,
    SHDR  = 4'b0100,
    EX1DR = 4'b0101,
    PSDR  = 4'b0110,
    EX2DR = 4'b0111,
    UPDR  = 4'b1000,
    SELIR = 4'b1001,
    CAPIR = 4'b1010,
    SHIR  = 4'b1011,
    EX1IR = 4'b1100,
    PSIR  = 4'b1101,
    EX2IR = 4'b1110,
    UPIR  = 4'b1111
  } bst_state_t;

  typedef enum logic [2:0] {
    SEL_BYP = 3'b000,
    SEL_BS  = 3'b001,
    SEL_ID  = 3'b010,
    SEL_USR = 3'b011,
    SEL_IFC = 3'b100,
    SEL_RRD = 3'b101,
    SEL_RWR = 3'b110
  } bst_sel_t;

endpackage : bst_pkg

/* File: src/bst_sync.sv */
// two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module bst_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_r <= '1;
      q_o    <= '1;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : bst_sync

/* File: src/bst_tap.sv */
// boundary scan test access port: tap controller, instruction and data chains
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  input  wire logic [BS_LEN-1:0]  bs_pin_i,
  input  wire logic [ID_LEN-1:0]  user_code_i,
  input  wire logic [RDATA_W-1:0] reg_rdata_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_o,
  output logic [2:0]              pullup_en_o,
  output logic [BS_LEN-1:0]       bs_out_o,
  output logic                    bs_drive_o,
  output logic                    bs_hiz_o,
  output logic                    host_if_off_o,
  output logic [RADDR_W-1:0]      reg_addr_o,
  output logic [RDATA_W-1:0]      reg_wdata_o,
  output logic                    reg_we_o
);
  logic             tck_s;
  logic             tms_s;
  logic             tdi_s;
  logic             tck_d_r;
  logic             tck_rise;
  logic             tck_fall;
  bst_state_t       state_r;
  bst_state_t       state_nxt;
  logic [IR_W-1:0]  ir_r;
  logic [IR_W-1:0]  ir_sh_r;
  logic [ID_LEN-1:0] dr_sh_r;
  bst_sel_t         sel;
  logic             bs_so;
  logic             tdo_nxt;
  logic             shifting;
  logic             if_off_r;
  logic [2:0]       ones_r;

  // tck, tms and tdi enter through one synchroniser
  bst_sync #(
    .W (3)
  ) u_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .d_i      ({tck_i, tms_i, tdi_i}),
    .q_o      ({tck_s, tms_s, tdi_s})
  );

  // edge finder on synchronised tck
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tck_d_r <= 1'b1;
    else
      tck_d_r <= tck_s;
  end

  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;
  assign shifting = (state_r == SHDR) || (state_r == SHIR);

  // next state from current state and sampled tms
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      TLR:   state_nxt = tms_s ? TLR   : RTI;
      RTI:   state_nxt = tms_s ? SELDR : RTI;
      SELDR: state_nxt = tms_s ? SELIR : CAPDR;
      CAPDR: state_nxt = tms_s ? EX1DR : SHDR;
      SHDR:  state_nxt = tms_s ? EX1DR : SHDR;
      EX1DR: state_nxt = tms_s ? UPDR  : PSDR;
      PSDR:  state_nxt = tms_s ? EX2DR : PSDR;
      EX2DR: state_nxt = tms_s ? UPDR  : SHDR;
      UPDR:  state_nxt = tms_s ? SELDR : RTI;
      SELIR: state_nxt = tms_s ? TLR   : CAPIR;
      CAPIR: state_nxt = tms_s ? EX1IR : SHIR;
      SHIR:  state_nxt = tms_s ? EX1IR : SHIR;
      EX1IR: state_nxt = tms_s ? UPIR  : PSIR;
      PSIR:  state_nxt = tms_s ? EX2IR : PSIR;
      EX2IR: state_nxt = tms_s ? UPIR  : SHIR;
      UPIR:  state_nxt = tms_s ? SELDR : RTI;
    endcase
  end

  // state moves only on a tck rise
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_r <= TLR;
    else if (tck_rise)
      state_r <= state_nxt;
  end

  // instruction decode; unknown codes fall to bypass
  always_comb
  begin
    unique case (ir_r)
      IR_SAMPLE, IR_EXTEST: sel = SEL_BS;
      IR_IDCODE:            sel = SEL_ID;
      IR_USER:              sel = SEL_USR;
      IR_IFSW:              sel = SEL_IFC;
      IR_RREAD:             sel = if_off_r ? SEL_RRD : SEL_BYP;
      IR_RWRITE:            sel = if_off_r ? SEL_RWR : SEL_BYP;
      default:              sel = SEL_BYP;
    endcase
  end

  // instruction chain and register
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ir_sh_r <= IR_CAPT;
      ir_r    <= IR_IDCODE;
    end
    else if (tck_rise)
    begin
      unique case (state_r)
        TLR:     ir_r    <= IR_IDCODE;
        CAPIR:   ir_sh_r <= IR_CAPT;
        SHIR:    ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};
        UPIR:    ir_r    <= ir_sh_r;
        default: ir_r    <= ir_r;
      endcase
    end
  end

  // data chain for every selection but the boundary
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      dr_sh_r <= DR_RST;
    else if (tck_rise && state_r == CAPDR)
    begin
      unique case (sel)
        SEL_BYP: dr_sh_r <= DR_RST;
        SEL_ID:  dr_sh_r <= ID_VALUE;
        SEL_USR: dr_sh_r <= user_code_i;
        SEL_IFC: dr_sh_r <= {{(ID_LEN-1){1'b0}}, if_off_r};
        SEL_RRD: dr_sh_r <= {{(ID_LEN-RACC_LEN){1'b0}}, reg_addr_o, reg_rdata_i};
        default: dr_sh_r <= dr_sh_r;
      endcase
    end
    else if (tck_rise && state_r == SHDR)
    begin
      unique case (sel)
        SEL_ID, SEL_USR:
          dr_sh_r <= {tdi_s, dr_sh_r[ID_LEN-1:1]};
        SEL_RRD, SEL_RWR:
          dr_sh_r <= {{(ID_LEN-RACC_LEN){1'b0}}, tdi_s, dr_sh_r[RACC_LEN-1:1]};
        default:
          dr_sh_r <= {{(ID_LEN-1){1'b0}}, tdi_s};
      endcase
    end
  end

  bst_bscan u_bscan (
    .clock_i   (clock_i),
    .arst_n_i  (arst_n_i),
    .capture_i (tck_rise && state_r == CAPDR && sel == SEL_BS),
    .shift_i   (tck_rise && state_r == SHDR && sel == SEL_BS),
    .update_i  (tck_rise && state_r == UPDR && sel == SEL_BS),
    .tdi_i     (tdi_s),
    .pin_i     (bs_pin_i),
    .so_o      (bs_so),
    .upd_o     (bs_out_o)
  );

  // interface off switch, cleared in test-logic-reset
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      if_off_r <= 1'b0;
    else if (tck_rise && state_r == TLR)
      if_off_r <= 1'b0;
    else if (tck_rise && state_r == UPDR && sel == SEL_IFC)
      if_off_r <= dr_sh_r[0];
  end

  assign host_if_off_o = if_off_r;

  // register address, write data and write strobe
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_addr_o  <= RADDR_RST;
      reg_wdata_o <= RDATA_RST;
      reg_we_o    <= 1'b0;
    end
    else
    begin
      reg_we_o <= 1'b0;
      if (tck_rise && state_r == UPDR && sel == SEL_RRD)
        reg_addr_o <= dr_sh_r[RACC_LEN-1:RDATA_W];
      else if (tck_rise && state_r == CAPDR && sel == SEL_RWR)
      begin
        reg_addr_o  <= dr_sh_r[RACC_LEN-1:RDATA_W];
        reg_wdata_o <= dr_sh_r[RDATA_W-1:0];
        reg_we_o    <= 1'b1;
      end
    end
  end

  // output bit of the chain being shifted
  always_comb
  begin
    if (state_r == SHIR)
      tdo_nxt = ir_sh_r[0];
    else if (sel == SEL_BS)
      tdo_nxt = bs_so;
    else
      tdo_nxt = dr_sh_r[0];
  end

  // tdo and its enable change on a tck fall
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tdo_o    <= 1'b1;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_o    <= shifting ? tdo_nxt : 1'b1;
      tdo_oe_o <= shifting;
    end
  end

  // pin takeover by the boundary cells
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bs_drive_o <= 1'b0;
      bs_hiz_o   <= 1'b0;
    end
    else
    begin
      bs_drive_o <= (ir_r == IR_EXTEST) || (ir_r == IR_CLAMP);
      bs_hiz_o   <= (ir_r == IR_HIGHZ);
    end
  end

  // pull-up enables for tck, tms, tdi
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pullup_en_o <= PULL_ON;
    else
      pullup_en_o <= PULL_ON;
  end

  // count of consecutive tms-high rises, for checking
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ones_r <= ONES_RST;
    else if (tck_rise)
      ones_r <= !tms_s ? ONES_RST : (ones_r == ONES_MAX) ? ONES_MAX : ones_r + 3'h1;
  end

  property p_five_ones;
    @(posedge clock_i) disable iff (!arst_n_i)
    (ones_r == ONES_MAX) |-> (state_r == TLR);
  endproperty
  a_five_ones: assert property (p_five_ones)
    else $error("five tms-high clocks did not reach reset state");

  property p_idle_hold;
    @(posedge clock_i) disable iff (!arst_n_i)
    !tck_rise |=> $stable(state_r) && $stable(ir_r) && $stable(dr_sh_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("state or chain changed without a tck rise");

  property p_tlr_ir;
    @(posedge clock_i) disable iff (!arst_n_i)
    (tck_rise && state_r == TLR) |=> (ir_r == IR_IDCODE);
  endproperty
  a_tlr_ir: assert property (p_tlr_ir)
    else $error("instruction not idcode after reset state");

  property p_tms_step;
    @(posedge clock_i) disable iff (!arst_n_i)
    (tck_rise && state_r == RTI && tms_s) |=> (state_r == SELDR);
  endproperty
  a_tms_step: assert property (p_tms_step)
    else $error("wrong state after idle with tms high");

  property p_ir_shift;
    @(posedge clock_i) disable iff (!arst_n_i)
    (tck_rise && state_r == SHIR) |=> (ir_sh_r[IR_W-1] == $past(tdi_s));
  endproperty
  a_ir_shift: assert property (p_ir_shift)
    else $error("tdi not shifted into instruction chain");

  property p_bypass;
    @(posedge clock_i) disable iff (!arst_n_i)
    (tck_rise && state_r == SHDR && sel == SEL_BYP) |=> (dr_sh_r[0] == $past(tdi_s));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass bit did not take tdi");

  property p_tdo_fall;
    @(posedge clock_i) disable iff (!arst_n_i)
    ($changed(tdo_o) || $changed(tdo_oe_o)) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo changed away from a tck fall");

  property p_tdo_oe;
    @(posedge clock_i) disable iff (!arst_n_i)
    (tck_fall && !shifting) |=> !tdo_oe_o;
  endproperty
  a_tdo_oe: assert property (p_tdo_oe)
    else $error("tdo driven outside a shift state");

  property p_write;
    @(posedge clock_i) disable iff (!arst_n_i)
    reg_we_o |-> if_off_r && $past(tck_rise && state_r == CAPDR && ir_r == IR_RWRITE);
  endproperty
  a_write: assert property (p_write)
    else $error("register write without capture under write access");

  property p_code6;
    @(posedge clock_i) disable iff (!arst_n_i)
    (ir_r == 4'h6 || ir_r > IR_RWRITE || ir_r == IR_CLAMP) |-> (sel == SEL_BYP);
  endproperty
  a_code6: assert property (p_code6)
    else $error("unassigned code did not select bypass");

endmodule : bst_tap

/* File: verification/bst_jtag_host.sv */
// test controller model: drives tck, tms, tdi and samples tdo
`timescale 1ns/1ps
module bst_jtag_host (
  input  wire logic clock_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  logic oe_seen;

  // idle: tck still low, tms and tdi at pull-up level
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    oe_seen = 1'b0;
  end

  // one tck period: 5 clocks low, 3 high; tdo taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clock_i);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (5) @(posedge clock_i);
    o = tdo_i;
    oe_seen = tdo_oe_i;
    tck_o <= 1'b1;
    repeat (2) @(posedge clock_i);
  endtask : step

  task automatic park();
    @(posedge clock_i);
    tck_o <= 1'b0;
    tms_o <= 1'b1;
    tdi_o <= 1'b1;
    repeat (5) @(posedge clock_i);
  endtask : park

  // five tms-high periods, then run-test/idle
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    park();
  endtask : tap_reset

  // from run-test/idle: capture, shift n bits lsb first, update, back to idle
  task automatic shift(input logic ir, input logic [31:0] din, input int n, input int hold,
                       output logic [31:0] dout, output logic oe_all);
    logic o;
    dout = 32'h0000_0000;
    oe_all = 1'b1;
    step(1'b1, 1'b1, o);
    if (ir)
      step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int k = 0; k < n; k++)
    begin
      if (k == n / 2)
        repeat (hold) @(posedge clock_i);
      step(k == n - 1, din[k], o);
      dout[k] = o;
      oe_all = oe_all & oe_seen;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    park();
  endtask : shift
endmodule : bst_jtag_host

/* File: verification/test_bst_tap.sv */
// testbench for the boundary scan test access port
`timescale 1ns/1ps
module test_bst_tap;
  import bst_pkg::*;

  logic               clock_i, arst_n_i, tck, tms, tdi, tdo, oe, drv, hiz, ifoff, we, oe_all;
  logic [2:0]         pu;
  logic [BS_LEN-1:0]  bs_pin, bs_out;
  logic [ID_LEN-1:0]  user_code, dout;
  logic [RADDR_W-1:0] raddr, we_addr;
  logic [RDATA_W-1:0] rdata, wdata, we_data;
  int                 fails, num_checks, we_cnt;

  bst_tap i_bst_tap (
    .clock_i       (clock_i),
    .arst_n_i      (arst_n_i),
    .tck_i         (tck),
    .tms_i         (tms),
    .tdi_i         (tdi),
    .bs_pin_i      (bs_pin),
    .user_code_i   (user_code),
    .reg_rdata_i   (rdata),
    .tdo_o         (tdo),
    .tdo_oe_o      (oe),
    .pullup_en_o   (pu),
    .bs_out_o      (bs_out),
    .bs_drive_o    (drv),
    .bs_hiz_o      (hiz),
    .host_if_off_o (ifoff),
    .reg_addr_o    (raddr),
    .reg_wdata_o   (wdata),
    .reg_we_o      (we)
  );

  bst_jtag_host i_bst_jtag_host (
    .clock_i  (clock_i),
    .tdo_i    (tdo),
    .tdo_oe_i (oe),
    .tck_o    (tck),
    .tms_o    (tms),
    .tdi_o    (tdi)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // register contents seen at the current address
  always @(posedge clock_i)
    rdata <= {1'b1, raddr} ^ 8'h5A;

  always @(posedge clock_i)
    if (we === 1'b1)
    begin
      we_cnt <= we_cnt + 1;
      we_addr <= raddr;
      we_data <= wdata;
    end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic sh(input logic ir, input logic [31:0] din, input int n, input int hold);
    i_bst_jtag_host.shift(ir, din, n, hold, dout, oe_all);
  endtask : sh

  task automatic ld(input logic [3:0] code);
    sh(1'b1, 32'(code), 4, 0);
    check_val(dout, 32'h0000_0001, "ir capture");
  endtask : ld

  task automatic test_reset_values();
    check_val(32'(oe), 32'h0000_0000, "tdo enable");
    check_val(32'(pu), 32'(PULL_ON), "pull-ups");
    check_val(32'({tdo, ifoff, drv, we}), 32'h0000_0008, "reset levels");
  endtask : test_reset_values

  task automatic test_idcode();
    i_bst_jtag_host.tap_reset();
    sh(1'b0, 32'h0000_0000, 32, 100);
    check_val(dout, ID_VALUE, "idcode");
    check_val(32'(oe_all), 32'h0000_0001, "tdo on in shift");
    check_val(32'({oe, tdo}), 32'h0000_0001, "tdo off");
  endtask : test_idcode

  task automatic test_bypass_codes();
    logic [3:0] codes [6] = '{IR_BYPASS, IR_CLAMP, IR_HIGHZ, 4'h6, 4'hB, 4'hF};
    foreach (codes[k])
    begin
      ld(codes[k]);
      check_val(32'({drv, hiz}), 32'({codes[k] == IR_CLAMP, codes[k] == IR_HIGHZ}),
                "pad control");
      sh(1'b0, 32'h0000_00B5, 8, 0);
      check_val(dout, 32'h0000_006A, "bypass");
    end
  endtask : test_bypass_codes

  task automatic test_user_code();
    ld(IR_USER);
    sh(1'b0, 32'h0000_0000, 32, 0);
    check_val(dout, user_code, "user code");
  endtask : test_user_code

  task automatic test_boundary();
    ld(IR_SAMPLE);
    sh(1'b0, 32'h0012_3456, 24, 0);
    check_val(dout, 32'(bs_pin), "sample");
    check_val(32'(bs_out), 32'h0012_3456, "preload");
    ld(IR_EXTEST);
    check_val(32'({drv, bs_out}), 32'h0112_3456, "extest drive");
  endtask : test_boundary

  task automatic test_tap_reset();
    logic o;
    ld(IR_BYPASS);
    for (int k = 0; k < 4; k++)
      i_bst_jtag_host.step(k < 2, 1'b1, o);
    i_bst_jtag_host.tap_reset();
    sh(1'b0, 32'h0000_0000, 32, 0);
    check_val(dout, ID_VALUE, "idcode after reset");
  endtask : test_tap_reset

  task automatic test_reg_access();
    int c0;
    ld(IR_IFSW);
    sh(1'b0, 32'h0000_0001, 1, 0);
    check_val(32'(ifoff), 32'h0000_0001, "interfaces off");
    ld(IR_RREAD);
    sh(1'b0, 32'h0000_2C00, 15, 0);
    check_val(dout, 32'h0000_00DA, "read capture");
    check_val(32'(raddr), 32'h0000_002C, "address update");
    sh(1'b0, 32'h0000_1100, 15, 0);
    check_val(dout, 32'h0000_2CF6, "read data");
    ld(IR_RWRITE);
    sh(1'b0, 32'h0000_4BE7, 15, 0);
    c0 = we_cnt;
    sh(1'b0, 32'h0000_0000, 15, 0);
    check_val(32'(we_cnt - c0), 32'h0000_0001, "write strobes");
    check_val(32'({we_addr, we_data}), 32'h0000_4BE7, "write");
    i_bst_jtag_host.tap_reset();
    check_val(32'(ifoff), 32'h0000_0000, "interfaces on");
    ld(IR_RREAD);
    sh(1'b0, 32'h0000_00B5, 8, 0);
    check_val(dout, 32'h0000_006A, "read locked to bypass");
  endtask : test_reg_access

  initial
  begin
    #1_000_000;
    fails++;
    give_verdict();
  end

  initial
  begin
    arst_n_i = 1'b0;
    bs_pin = 24'hA5_3C96;
    user_code = 32'hC0DE_1234;
    rdata = 8'h00;
    fails = 0;
    num_checks = 0;
    we_cnt = 0;
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    test_reset_values();
    test_idcode();
    test_bypass_codes();
    test_user_code();
    test_boundary();
    test_tap_reset();
    test_reg_access();
    give_verdict();
  end
endmodule : test_bst_tap
